// File: rtl/fault_policy_pkg.sv
// Constants and types shared by the current fault policy block.
// Assumes a 40 MHz system clock and a byte-wide command port.
package fault_policy_pkg;

  // ****************************************
  // Command codes and field layout
  // ****************************************
  localparam logic [7:0] OC_POLICY_CODE = 8'hE5;
  localparam logic [7:0] UC_POLICY_CODE = 8'hE6;
  localparam logic [7:0] STATUS_CODE = 8'hF0;
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int UNITS_MSB = 2;
  localparam int UNITS_LSB = 0;
  localparam int STATUS_OC_BIT = 0;
  localparam int STATUS_UC_BIT = 1;
  localparam logic [7:0] POLICY_RESET = 8'h00;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_CONTINUE = 2'h1;
  localparam logic [1:0] RESP_DISABLE = 2'h2;
  localparam logic [1:0] RESP_HOLD = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // ****************************************
  // Timing
  // ****************************************
  // Kept in ns so every figure fits a 32-bit int
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CONT_UNIT_NS = 10_000_000;
  localparam int unsigned RETRY_UNIT_NS = 8_200_000;
  localparam int unsigned CONT_UNIT_CYCLES = CONT_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned RETRY_UNIT_CYCLES = RETRY_UNIT_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 22;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CONTINUE, ST_OFF, ST_TRY, ST_HOLD, ST_LATCHED
  } engine_state_type;

  // Units times unit length, never below one cycle
  function automatic logic [TIMER_W-1:0] delay_cycles(input logic [2:0] units, input int unsigned unit_cyc);
    logic [TIMER_W-1:0] prod;
    prod = TIMER_W'(units * unit_cyc);
    delay_cycles = (units == 3'h0) ? TIMER_W'(1) : prod;
  endfunction

endpackage

// File: rtl/fault_policy_if.sv
// Carrier between the top level and one fault policy engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface fault_policy_if;
  logic [7:0] policy;
  logic reload;
  logic clear;
  logic run;
  logic fault;
  logic allow_out;
  logic fault_evt;
  logic latched;

  modport engine (input policy, reload, clear, run, fault, output allow_out, fault_evt, latched);
  modport ctrl (output policy, reload, clear, run, fault, input allow_out, fault_evt, latched);
endinterface
`default_nettype wire

// File: rtl/fault_policy_engine.sv
// One fault response engine: modes, delays and restart attempts.
// Assumes a level fault input synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module fault_policy_engine #(
  parameter int unsigned CONT_CYC = fault_policy_pkg::CONT_UNIT_CYCLES,
  parameter int unsigned RETRY_CYC = fault_policy_pkg::RETRY_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Policy carrier
  fault_policy_if.engine pif
);
  import fault_policy_pkg::*;

  engine_state_type state_reg, state_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic [2:0] left_reg, left_next;
  logic fault_q_reg;
  logic [3:0] used_reg;

  wire [1:0] resp = pif.policy[RESP_MSB:RESP_LSB];
  wire [2:0] retry = pif.policy[RETRY_MSB:RETRY_LSB];
  wire [2:0] units = pif.policy[UNITS_MSB:UNITS_LSB];
  wire [TIMER_W-1:0] cont_cyc = delay_cycles(units, CONT_CYC);
  wire [TIMER_W-1:0] retry_cyc = delay_cycles(units, RETRY_CYC);
  wire cont_done = timer_reg >= cont_cyc - TIMER_W'(1);
  wire retry_done = timer_reg >= retry_cyc - TIMER_W'(1);
  wire forever_retry = retry == RETRY_FOREVER;
  wire exhausted = (retry == RETRY_NONE) || (left_reg == 3'h0 && !forever_retry);
  wire timing = state_reg == ST_CONTINUE || state_reg == ST_OFF || state_reg == ST_TRY;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    timer_next = timing && timer_reg != '1 ? timer_reg + TIMER_W'(1) : timer_reg;
    left_next = left_reg;
    if (!pif.run) begin
      state_next = ST_IDLE;
      timer_next = '0;
      left_next = retry;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          timer_next = '0;
          if (!pif.fault || pif.reload) left_next = retry;
          if (pif.fault) begin
            unique case (resp)
              RESP_IGNORE: state_next = ST_IDLE;
              RESP_CONTINUE: state_next = ST_CONTINUE;
              RESP_DISABLE: state_next = retry == RETRY_NONE ? ST_LATCHED : ST_OFF;
              RESP_HOLD: state_next = ST_HOLD;
            endcase
          end
        end
        ST_CONTINUE: begin
          if (!pif.fault) state_next = ST_IDLE;
          else if (cont_done) begin
            state_next = retry == RETRY_NONE ? ST_LATCHED : ST_OFF;
            timer_next = '0;
          end
        end
        ST_OFF: begin
          if (retry_done) begin
            state_next = ST_TRY;
            timer_next = '0;
            left_next = forever_retry ? left_reg : left_reg - 3'h1;
          end
        end
        ST_TRY: begin
          if (pif.fault) state_next = exhausted ? ST_LATCHED : ST_OFF;
          else if (retry_done) state_next = ST_IDLE;
        end
        ST_HOLD: begin
          if (!pif.fault) state_next = ST_IDLE;
        end
        ST_LATCHED: begin
          if (pif.clear) state_next = ST_IDLE;
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      left_reg <= '0;
      fault_q_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      left_reg <= left_next;
      fault_q_reg <= pif.fault;
    end
  end

  assign pif.fault_evt = pif.fault && !fault_q_reg;
  assign pif.allow_out = !(state_reg == ST_OFF || state_reg == ST_HOLD || state_reg == ST_LATCHED);
  assign pif.latched = state_reg == ST_LATCHED;

  // ****************************************
  // Checks
  // ****************************************
  // Attempts per episode, checker only
  always_ff @(posedge clk) begin
    if (rst || state_reg == ST_IDLE) used_reg <= '0;
    else if (state_reg == ST_OFF && state_next == ST_TRY && used_reg != 4'hF) used_reg <= used_reg + 4'h1;
  end

  ignore_mode_a: assert property (@(posedge clk) disable iff (rst)
    pif.run && resp == RESP_IGNORE && state_reg == ST_IDLE |=> pif.allow_out)
    else $error("ignore mode disabled output");
  continue_on_a: assert property (@(posedge clk) disable iff (rst)
    pif.run && state_reg == ST_IDLE && pif.fault && resp == RESP_CONTINUE
      |=> state_reg == ST_CONTINUE && pif.allow_out)
    else $error("output dropped during continue delay");
  disable_now_a: assert property (@(posedge clk) disable iff (rst)
    pif.run && state_reg == ST_IDLE && pif.fault && resp == RESP_DISABLE |=> !pif.allow_out)
    else $error("disable mode did not cut output");
  hold_resume_a: assert property (@(posedge clk) disable iff (rst)
    pif.run && state_reg == ST_HOLD && !pif.fault |=> pif.allow_out)
    else $error("hold mode did not resume");
  no_retry_a: assert property (@(posedge clk) disable iff (rst)
    pif.latched && pif.run && !pif.clear |=> pif.latched)
    else $error("latched off released without clear");
  attempt_limit_a: assert property (@(posedge clk) disable iff (rst)
    !forever_retry && !pif.reload |-> used_reg <= {1'b0, retry})
    else $error("too many restart attempts");
  endless_retry_a: assert property (@(posedge clk) disable iff (rst)
    forever_retry && state_reg == ST_TRY |=> !pif.latched)
    else $error("continuous retry gave up");
  cont_time_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_CONTINUE && !pif.reload |-> timer_reg < cont_cyc)
    else $error("continue delay overran");
  spacing_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == ST_OFF && $past(state_reg) == ST_TRY |-> timer_reg <= retry_cyc)
    else $error("retry spacing overran");
  reload_a: assert property (@(posedge clk) disable iff (rst)
    pif.run && state_reg == ST_IDLE && !pif.fault |=> left_reg == $past(retry))
    else $error("attempt counter not reloaded");
endmodule // fault_policy_engine
`default_nettype wire

// File: rtl/current_fault_retry_policy.sv
// Top of the output current fault policy block.
// Assumes a command port decoded from the host link, one byte per command.
// Function
// - Response 00 keeps the output running through the fault while still reporting it.
// - Every detected fault pulls the alert low and sets its status bit.
// - Response 01 keeps running for the delay, then applies the retry setting if the fault remains.
// - Response 10 disables the output at once and then follows the retry setting.
// - Response 11 holds the output off only while the fault is present.
// - Retry 000 makes no restart; the output stays off until the fault is cleared.
// - Retry 101 and 110 make exactly five and six restart attempts.
// - Retry 111 retries until output off, power loss or another shutdown fault.
// - The delay field counts 0 to 7 units of 10 ms for the continue time.
// - The same field counts 8.2 ms units between the starts of restart attempts.
// - The undercurrent policy is a read/write byte at 0xE6 and sets the undercurrent bit.
// - Retry 001 to 100 make one to four attempts, then stay off until cleared.
// - The overcurrent policy at 0xE5 has the same layout and sets the overcurrent bit.
`timescale 1ns/1ps
`default_nettype none
module current_fault_retry_policy #(
  parameter int unsigned CONT_CYC = fault_policy_pkg::CONT_UNIT_CYCLES,
  parameter int unsigned RETRY_CYC = fault_policy_pkg::RETRY_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Command port
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic [7:0] CMD_CODE,
  input wire logic [7:0] CMD_WDATA,
  output logic [7:0] CMD_RDATA,
  output logic CMD_ACK,
  output logic CMD_NACK,
  // Fault and power control
  input wire logic IOUT_OC_FAULT,
  input wire logic IOUT_UC_FAULT,
  input wire logic OUTPUT_ON,
  input wire logic OTHER_SHUTDOWN,
  input wire logic FAULT_CLEAR,
  output logic OUTPUT_EN,
  output logic HOST_ALERT_OUT_N
);
  import fault_policy_pkg::*;

  logic [7:0] oc_policy_reg;
  logic [7:0] uc_policy_reg;
  logic [7:0] rdata_reg;
  logic ack_reg;
  logic nack_reg;
  logic alert_n_reg;
  logic out_en_reg;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic oc_reload_reg;
  logic uc_reload_reg;

  fault_policy_if oc_if ();
  fault_policy_if uc_if ();

  // ****************************************
  // Command decode
  // ****************************************
  wire access = CMD_WR || CMD_RD;
  wire hit_oc = CMD_CODE == OC_POLICY_CODE;
  wire hit_uc = CMD_CODE == UC_POLICY_CODE;
  // Status is read-only, so only a read of it is known
  wire hit_st = CMD_CODE == STATUS_CODE && CMD_RD;
  wire known = hit_oc || hit_uc || hit_st;
  wire wr_uc = CMD_WR && hit_uc;
  wire wr_oc = CMD_WR && hit_oc;
  wire rd_ok = CMD_RD && known;
  wire ack_next = access && known;
  wire nack_next = access && !known;
  wire [7:0] status_byte = {6'h00, status_reg};
  wire [7:0] rd_mux = hit_oc ? oc_policy_reg : hit_uc ? uc_policy_reg : status_byte;
  wire run = OUTPUT_ON && !OTHER_SHUTDOWN;
  wire [1:0] evt = {uc_if.fault_evt, oc_if.fault_evt};
  // Both engines must allow before the pin turns on
  wire out_next = run && oc_if.allow_out && uc_if.allow_out;

  // set beats clear on the status bits
  assign status_next = evt | (FAULT_CLEAR ? 2'h0 : status_reg);

  // ****************************************
  // Policy bytes
  // ****************************************
  // A refused write never reaches these bytes
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      oc_policy_reg <= POLICY_RESET;
      uc_policy_reg <= POLICY_RESET;
    end else begin
      if (wr_oc) oc_policy_reg <= CMD_WDATA;
      if (wr_uc) uc_policy_reg <= CMD_WDATA;
    end
  end

  // ****************************************
  // Host answer
  // ****************************************
  // Registered answer, one cycle after the request
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_reg <= 8'h00;
      ack_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      if (rd_ok) rdata_reg <= rd_mux;
      ack_reg <= ack_next;
      nack_reg <= nack_next;
    end
  end

  // ****************************************
  // Status and alert
  // ****************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      status_reg <= 2'h0;
      alert_n_reg <= 1'b1;
    end else begin
      status_reg <= status_next;
      alert_n_reg <= status_next == 2'h0;
    end
  end

  // ****************************************
  // Output enable and reload
  // ****************************************
  // Reload pulse lets an idle engine pick up fresh attempts
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      out_en_reg <= 1'b0;
      oc_reload_reg <= 1'b0;
      uc_reload_reg <= 1'b0;
    end else begin
      out_en_reg <= out_next;
      oc_reload_reg <= wr_oc;
      uc_reload_reg <= wr_uc;
    end
  end

  // ****************************************
  // Engines
  // ****************************************
  assign oc_if.policy = oc_policy_reg;
  assign oc_if.reload = oc_reload_reg;
  assign oc_if.clear = FAULT_CLEAR;
  assign oc_if.run = run;
  assign oc_if.fault = IOUT_OC_FAULT;
  assign uc_if.policy = uc_policy_reg;
  assign uc_if.reload = uc_reload_reg;
  assign uc_if.clear = FAULT_CLEAR;
  assign uc_if.run = run;
  assign uc_if.fault = IOUT_UC_FAULT;

  fault_policy_engine #(.CONT_CYC(CONT_CYC), .RETRY_CYC(RETRY_CYC)) oc_engine (
    .clk(CLK),
    .rst(SYS_RST),
    .pif(oc_if)
  );

  fault_policy_engine #(.CONT_CYC(CONT_CYC), .RETRY_CYC(RETRY_CYC)) uc_engine (
    .clk(CLK),
    .rst(SYS_RST),
    .pif(uc_if)
  );

  assign CMD_RDATA = rdata_reg;
  assign CMD_ACK = ack_reg;
  assign CMD_NACK = nack_reg;
  // Registered so combinational decode glitches never reach the pin
  assign OUTPUT_EN = out_en_reg;
  assign HOST_ALERT_OUT_N = alert_n_reg;

  // ****************************************
  // Checks
  // ****************************************
  alert_low_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    evt != 2'h0 |=> !HOST_ALERT_OUT_N && (status_reg & $past(evt)) == $past(evt))
    else $error("fault did not raise alert");
  uc_byte_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CMD_RD && hit_uc && !CMD_WR |=> CMD_RDATA == $past(uc_policy_reg) && CMD_ACK)
    else $error("undercurrent byte readback wrong");
  uc_status_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    uc_if.fault_evt |=> status_reg[STATUS_UC_BIT])
    else $error("undercurrent bit not set");
  oc_status_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    oc_if.fault_evt |=> status_reg[STATUS_OC_BIT])
    else $error("overcurrent bit not set");
  out_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !oc_if.allow_out || !uc_if.allow_out || !run |=> !OUTPUT_EN)
    else $error("output left on while an engine holds it off");

  oc_byte_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CMD_RD && hit_oc && !CMD_WR |=> CMD_RDATA == $past(oc_policy_reg) && CMD_ACK)
    else $error("overcurrent byte readback wrong");
  uc_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr_uc |=> uc_policy_reg == $past(CMD_WDATA))
    else $error("undercurrent byte write lost");
  oc_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr_oc |=> oc_policy_reg == $past(CMD_WDATA))
    else $error("overcurrent byte write lost");
  ack_pulse_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    access && known |=> CMD_ACK && !CMD_NACK)
    else $error("known request not acknowledged");
  refuse_nack_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    access && !known |=> CMD_NACK && !CMD_ACK)
    else $error("refused request not flagged");
  rdata_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !rd_ok |=> CMD_RDATA == $past(CMD_RDATA))
    else $error("read data changed without a read");
  alert_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !FAULT_CLEAR && !HOST_ALERT_OUT_N |=> !HOST_ALERT_OUT_N)
    else $error("alert released without clear");
  alert_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    FAULT_CLEAR && evt == 2'h0 |=> HOST_ALERT_OUT_N)
    else $error("alert stuck after clear");
endmodule // current_fault_retry_policy
`default_nettype wire

// File: testbench/pmbus_host_model.sv
// Host side of the command port: single byte reads and writes.
// Assumes the caller runs on the same clock as the block.
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_nack
);
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
  end

  // ****************************************
  // Byte transfer
  // ****************************************
  // byte read or write
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data,
                      output logic [7:0] rdata, output logic [7:0] rsp);
    @(posedge clk);
    #1;
    cmd_wr = wr;
    cmd_rd = ~wr;
    cmd_code = code;
    cmd_wdata = data;
    @(posedge clk);
    #1;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    // Released lines must not keep looking valid
    cmd_code = ~code;
    cmd_wdata = ~data;
    rdata = cmd_rdata;
    rsp = {6'h00, cmd_ack, cmd_nack};
  endtask
endmodule // pmbus_host_model
`default_nettype wire

// File: testbench/test_current_fault_retry_policy.sv
// Self-checking bench for the current fault policy block.
// Assumes short delay parameters so the run stays a few thousand cycles.
`timescale 1ns/1ps
`default_nettype none
module test_current_fault_retry_policy;
  import fault_policy_pkg::*;
  localparam int unsigned CONT = 20;
  localparam int unsigned SPACE = 16;
  logic clk;
  logic sys_rst;
  logic oc_fault;
  logic uc_fault;
  logic output_on;
  logic other_shutdown;
  logic fault_clear;
  logic cmd_wr;
  logic cmd_rd;
  logic [7:0] cmd_code;
  logic [7:0] cmd_wdata;
  logic [7:0] cmd_rdata;
  logic cmd_ack;
  logic cmd_nack;
  logic output_en;
  logic alert_n;
  logic [7:0] rd;
  logic [7:0] rsp;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  // ****************************************
  // Clock and instances
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  pmbus_host_model host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack));
  current_fault_retry_policy #(.CONT_CYC(CONT), .RETRY_CYC(SPACE)) dut (.CLK(clk), .SYS_RST(sys_rst),
    .CMD_WR(cmd_wr), .CMD_RD(cmd_rd), .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata), .CMD_RDATA(cmd_rdata),
    .CMD_ACK(cmd_ack), .CMD_NACK(cmd_nack), .IOUT_OC_FAULT(oc_fault), .IOUT_UC_FAULT(uc_fault),
    .OUTPUT_ON(output_on), .OTHER_SHUTDOWN(other_shutdown), .FAULT_CLEAR(fault_clear),
    .OUTPUT_EN(output_en), .HOST_ALERT_OUT_N(alert_n));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_chk(input logic [7:0] code, input logic [7:0] data, input logic [7:0] exp);
    host.xfer(1'b1, code, data, rd, rsp);
    check(rsp, exp);
  endtask
  task automatic rd_chk(input logic [7:0] code, input logic [7:0] exp);
    host.xfer(1'b0, code, 8'h00, rd, rsp);
    check(rsp, 8'h02);
    check(rd, exp);
  endtask
  // Leaves the engines idle and the output running again
  task automatic recover();
    output_on = 1'b0;
    fault_clear = 1'b1;
    step(1);
    fault_clear = 1'b0;
    output_on = 1'b1;
    step(3);
    check(8'(output_en), 8'h01);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_regs();
    rd_chk(UC_POLICY_CODE, POLICY_RESET);
    rd_chk(OC_POLICY_CODE, POLICY_RESET);
    wr_chk(UC_POLICY_CODE, 8'h5A, 8'h02);
    rd_chk(UC_POLICY_CODE, 8'h5A);
    wr_chk(STATUS_CODE, 8'hFF, 8'h01);
    wr_chk(8'h12, 8'h00, 8'h01);
    rd_chk(STATUS_CODE, 8'h00);
    wr_chk(UC_POLICY_CODE, 8'h00, 8'h02);
    $display("test_regs done");
  endtask
  task automatic test_ignore();
    uc_fault = 1'b1;
    step(2);
    check(8'(alert_n), 8'h00);
    step(20);
    check(8'(output_en), 8'h01);
    rd_chk(STATUS_CODE, 8'h02);
    uc_fault = 1'b0;
    recover();
    check(8'(alert_n), 8'h01);
    $display("test_ignore done");
  endtask
  task automatic test_hold();
    wr_chk(UC_POLICY_CODE, 8'hC0, 8'h02);
    uc_fault = 1'b1;
    step(23);
    check(8'(output_en), 8'h00);
    uc_fault = 1'b0;
    step(4);
    check(8'(output_en), 8'h01);
    recover();
    $display("test_hold done");
  endtask
  task automatic test_continue();
    int cnt;
    cnt = 0;
    wr_chk(UC_POLICY_CODE, 8'h43, 8'h02);
    uc_fault = 1'b1;
    step(1);
    while (output_en === 1'b1 && cnt < 200) begin
      step(1);
      cnt++;
    end
    // Continue time spans three units, plus the output register
    check(8'(cnt >= 3 * CONT - 1 && cnt <= 3 * CONT + 3), 8'h01);
    uc_fault = 1'b0;
    step(100);
    check(8'(output_en), 8'h00);
    recover();
    wr_chk(UC_POLICY_CODE, 8'h00, 8'h02);
    $display("test_continue done");
  endtask
  task automatic test_retry(input logic [2:0] retry, input int exp);
    int tries;
    int last;
    int waited;
    tries = 0;
    last = 0;
    wr_chk(OC_POLICY_CODE, {RESP_DISABLE, retry, 3'h2}, 8'h02);
    rd_chk(OC_POLICY_CODE, {RESP_DISABLE, retry, 3'h2});
    oc_fault = 1'b1;
    step(1);
    oc_fault = 1'b0;
    step(2);
    check(8'(output_en), 8'h00);
    while (tries < 8) begin
      waited = 0;
      while (output_en !== 1'b1 && waited < 4 * SPACE) begin
        step(1);
        waited++;
      end
      if (output_en !== 1'b1) break;
      // Attempt starts lie two units apart
      if (tries > 0) check(8'(cyc - last), 8'(2 * SPACE));
      last = cyc;
      tries++;
      oc_fault = 1'b1;
      step(1);
      oc_fault = 1'b0;
      step(3);
    end
    check(8'(tries), 8'(exp));
    if (retry == RETRY_FOREVER) begin
      // Another shutdown ends continuous retry
      other_shutdown = 1'b1;
      step(3);
      check(8'(output_en), 8'h00);
      step(4 * SPACE);
      check(8'(output_en), 8'h00);
      other_shutdown = 1'b0;
    end
    rd_chk(STATUS_CODE, 8'h01);
    recover();
    $display("test_retry %0d done", retry);
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(25 * 40000);
    num_errors++;
    end_of_test();
  end
  initial begin
    sys_rst = 1'b1;
    oc_fault = 1'b0;
    uc_fault = 1'b0;
    output_on = 1'b0;
    other_shutdown = 1'b0;
    fault_clear = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    check({6'h00, output_en, alert_n}, 8'h01);
    test_regs();
    output_on = 1'b1;
    step(3);
    test_ignore();
    test_hold();
    test_continue();
    for (int r = 0; r < 8; r++) test_retry(3'(r), (r == 7) ? 8 : r);
    test_retry(3'h2, 2);
    end_of_test();
  end
endmodule // test_current_fault_retry_policy
`default_nettype wire
